// ==== src/ssp_pkg.sv ====
// constants of the serial peripheral port
package ssp_pkg;
	localparam int          REG_DW          = 16;
	localparam int          REG_AW          = 5;
	localparam logic [4:0]  ADDR_CTRL_A     = 5'h00;
	localparam logic [4:0]  ADDR_CTRL_B     = 5'h04;
	localparam logic [4:0]  ADDR_DATA_LO    = 5'h08;
	localparam logic [4:0]  ADDR_DATA_HI    = 5'h0C;
	localparam logic [4:0]  ADDR_IRQ_CLR    = 5'h10;
	// control_register_a fields
	localparam int          CA_ON           = 0;
	localparam int          CA_SLAVE        = 1;
	localparam int          CA_POL          = 2;
	localparam int          CA_PHA          = 3;
	localparam int          CA_WORD_LO      = 4;
	localparam int          CA_IDLE         = 6;
	localparam int          CA_RST          = 7;
	localparam int          CA_FORCE        = 8;
	localparam int          CA_DIV_LO       = 9;
	localparam int          CA_CE_USE       = 11;
	localparam int          CA_IRQ_EN       = 12;
	localparam logic [15:0] CA_RESET        = 16'h0000;
	localparam logic [15:0] CA_WMASK        = 16'h1F7F;
	// control_register_b fields
	localparam int          CB_FIFO_LO      = 0;
	localparam int          CB_NINTH        = 2;
	localparam int          CB_BUSY         = 3;
	localparam int          CB_TXH          = 4;
	localparam int          CB_DONE         = 5;
	localparam logic [2:0]  CB_RESET        = 3'h3;
	// word size codes
	localparam logic [1:0]  WORD_8          = 2'h0;
	localparam logic [1:0]  WORD_16         = 2'h1;
	localparam logic [1:0]  WORD_32         = 2'h2;
	localparam logic [1:0]  WORD_9          = 2'h3;
	// fifo usage codes
	localparam logic [1:0]  FIFO_BOTH       = 2'h0;
	localparam logic [1:0]  FIFO_RX_ONLY    = 2'h1;
	localparam logic [1:0]  FIFO_TX_ONLY    = 2'h2;
	localparam logic [1:0]  FIFO_NONE       = 2'h3;
	// timing
	localparam longint      SYS_CLK_HZ      = 25_000_000;
	localparam longint      LINE_CLK_MAX_HZ = 8_000_000;
	localparam longint      MIN_HALF_CYC    = (SYS_CLK_HZ + 2 * LINE_CLK_MAX_HZ - 1) / (2 * LINE_CLK_MAX_HZ);
	localparam int          FIFO_DEPTH      = 4;
	// two-flop input lag plus one: shortest half period that still samples fresh data
	localparam int          SYNC_MIN_HALF   = 3;
endpackage

// ==== src/ssp_fifo_if.sv ====
// handshake bundle between the port and its word fifos
`timescale 1ns/1ps
`default_nettype none
interface ssp_fifo_if #(parameter int W = 32, parameter int D = 4);
	logic                   push;
	logic [W-1:0]           wdata;
	logic                   pop;
	logic                   flush;
	logic [$clog2(D+1)-1:0] limit;
	logic [W-1:0]           rdata;
	logic                   full;
	logic                   empty;
	modport user (output push, wdata, pop, flush, limit, input rdata, full, empty);
	modport store (input push, wdata, pop, flush, limit, output rdata, full, empty);
endinterface
`default_nettype wire

// ==== src/ssp_fifo.sv ====
// word fifo with a run-time capacity limit
`timescale 1ns/1ps
`default_nettype none
module ssp_fifo #(
	parameter int W = 32,
	parameter int D = 4
) (
	input wire logic sys_clk,
	input wire logic rst,
	ssp_fifo_if.store f
);
	localparam int AW = $clog2(D);
	localparam int CW = $clog2(D + 1);

	if (D < 2 || (D & (D - 1)) != 0)
	begin : g_chk
		$error("ssp_fifo depth must be a power of two, at least 2");
	end

	logic [W-1:0]  mem [D];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [CW-1:0] cnt;
	wire           do_push = f.push & ~f.full;
	wire           do_pop  = f.pop & ~f.empty;

	assign f.full  = cnt >= f.limit;
	assign f.empty = cnt == '0;
	assign f.rdata = mem[rp];

	always_ff @(posedge sys_clk)
	begin
		if (do_push)
			mem[wp] <= f.wdata;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
		end
		else if (f.flush)
		begin
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
		end
		else
		begin
			wp  <= wp + AW'(do_push);
			rp  <= rp + AW'(do_pop);
			cnt <= cnt + CW'(do_push) - CW'(do_pop);
		end
	end
endmodule // ssp_fifo
`default_nettype wire

// ==== src/ssp_port.sv ====
// serial peripheral port: registers, clock divider, shift engine
//
// Overview of operation
// R1 - Words of 8, 16, 32 bits either role; 9-bit words transmitted as master.
// R2 - Master line clock is source clock over 1, 2, 4, 8, kept at most 8 MHz; code divides by 6, 6, 8, 16.
// R3 - Software sets pins, then mode, then block_on last.
// R4 - Writing the low data word starts a master transfer; high word goes first.
// R5 - Low word write sets holding full; moving to shift clears it; bits shift.
// R6 - After last clock set done and pending flags, copy received bits to data.
// R7 - Irq gated by mask; clear write clears source; unread rx data holds irq.
// R8 - Slave chosen by slave_select_mode; serial clock pin must be input.
// R9 - Each active serial clock edge captures one bit in, presents one bit out.
// R10 - External master clock below a quarter of the port clock.
// R11 - Chip enable gates slave clocking; release mid-word resets shift buffer.
// R12 - Clock polarity and phase bits give modes 0 to 3.
// R13 - Idle output shows idle level as master, and as slave in modes 0, 2.
// R14 - Modes 1, 3 keep last bit; engine reset or force returns idle level.
// R15 - Usage 10: tx fifo only; received words overwrite data registers.
// R16 - Usage 10: irq while tx space, holding full when full, busy ends after.
// R17 - Usage 01: rx fifo only; starts at once, sends tx words, zero at reset.
// R18 - Usage 01 master runs until rx fifo full; slave follows external master.
// R19 - Exact N-word reads follow the documented drain sequence by software.
// R20 - Usage 00: both fifos; holding full means tx full, irq means rx data.
// R21 - Dma with fifo off needs one cpu write first.
// R22 - Word code 11: ninth bit value leads, fifos 8-bit, leading rx bit lost.
// R23 - Most significant bit first; transfer_active set while shifting.
// R24 - Reset usage code is 11, one holding register each way.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ssp_port
	import ssp_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic [REG_AW-1:0] reg_addr,
	input  wire logic [REG_DW-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [REG_DW-1:0] reg_rdata,
	input  wire logic              sclk_i,
	output logic                   sclk_o,
	output logic                   sclk_oe,
	input  wire logic              serial_in_pin,
	output logic                   serial_out_pin,
	input  wire logic              chip_enable_n,
	output logic                   irq_line
);
	localparam int CW = $clog2(DEPTH + 1);
	localparam int HALF_FLOOR = (int'(MIN_HALF_CYC) > SYNC_MIN_HALF) ? int'(MIN_HALF_CYC) : SYNC_MIN_HALF;

	if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_chk
		$error("ssp_port depth must be a power of two, at least 4");
	end

	typedef enum logic {SSP_IDLE, SSP_SHIFT} ssp_state_e;

	ssp_state_e  st;
	logic [15:0] ctrl_a;
	logic [2:0]  ctrl_b;
	logic [15:0] tx_hi;
	logic [15:0] tx_lo;
	logic [31:0] rx_word;
	logic [31:0] sh;
	logic [31:0] ld_q;
	logic        ld_msb;
	logic        out_bit;
	logic        hold_lsb;
	logic [5:0]  bits;
	logic [3:0]  div_cnt;
	logic        pend;
	logic        done;
	logic        sclk_m;
	logic        sclk_s;
	logic        sclk_d;
	logic        sdi_m;
	logic        sdi_s;
	logic        cen_m;
	logic        cen_s;

	ssp_fifo_if #(.W(32), .D(DEPTH)) txf ();
	ssp_fifo_if #(.W(32), .D(DEPTH)) rxf ();

	ssp_fifo #(.W(32), .D(DEPTH)) u_txf (
		.sys_clk (sys_clk),
		.rst     (rst),
		.f       (txf)
	);

	ssp_fifo #(.W(32), .D(DEPTH)) u_rxf (
		.sys_clk (sys_clk),
		.rst     (rst),
		.f       (rxf)
	);

	// control fields
	wire       on     = ctrl_a[CA_ON];
	wire       slave  = ctrl_a[CA_SLAVE];
	wire       pol    = ctrl_a[CA_POL];
	wire       pha    = ctrl_a[CA_PHA];
	wire [1:0] wsz    = ctrl_a[CA_WORD_LO +: 2];
	wire       idle   = ctrl_a[CA_IDLE];
	wire       force_o = ctrl_a[CA_FORCE];
	wire [1:0] div    = ctrl_a[CA_DIV_LO +: 2];
	wire       ce_use = ctrl_a[CA_CE_USE];
	wire       irq_en = ctrl_a[CA_IRQ_EN];
	wire [1:0] fmode  = ctrl_b[CB_FIFO_LO +: 2];
	wire       ninth  = ctrl_b[CB_NINTH];
	wire       master = ~slave;

	// bus decode
	wire wr_ca  = reg_wr & (reg_addr == ADDR_CTRL_A);
	wire wr_cb  = reg_wr & (reg_addr == ADDR_CTRL_B);
	wire wr_lo  = reg_wr & (reg_addr == ADDR_DATA_LO);
	wire wr_hi  = reg_wr & (reg_addr == ADDR_DATA_HI);
	wire wr_clr = reg_wr & (reg_addr == ADDR_IRQ_CLR);
	wire rd_lo  = reg_rd & (reg_addr == ADDR_DATA_LO);
	wire eng_rst = wr_ca & reg_wdata[CA_RST];

	// word length and fifo capacity
	wire [5:0]  len = (wsz == WORD_32) ? 6'd32 : // R1
		(wsz == WORD_16) ? 6'd16 :
		(wsz == WORD_9) ? 6'd9 : 6'd8;
	wire [4:0]  top = 5'(len - 6'd1);
	wire [31:0] rx_mask = (wsz == WORD_32) ? 32'hFFFF_FFFF :
		(wsz == WORD_16) ? 32'h0000_FFFF : 32'h0000_00FF; // R22
	wire [CW-1:0] word_lim = (wsz == WORD_32) ? CW'(DEPTH / 4) :
		(wsz == WORD_16) ? CW'(DEPTH / 2) : CW'(DEPTH);

	// fifo roles per usage code
	wire rx_used = (fmode == FIFO_BOTH) | (fmode == FIFO_RX_ONLY); // R15 R17
	wire tx_used = (fmode != FIFO_RX_ONLY);
	wire tx_ok   = ~tx_used | ~txf.empty; // R4 R17
	wire rx_ok   = ~rx_used | ~rxf.full; // R18
	wire start   = on & (st == SSP_IDLE) & tx_ok & rx_ok & ~eng_rst;
	wire abort   = eng_rst | ~on;

	// master line clock timing
	wire [3:0] half_raw = 4'(1) << div; // R2
	wire [3:0] half = (half_raw < 4'(HALF_FLOOR)) ? 4'(HALF_FLOOR) : half_raw; // R2
	wire       m_tick = master & (st == SSP_SHIFT) & (div_cnt == half - 4'd1);

	// active edges in both roles
	wire ce_ok   = ~ce_use | ~cen_s; // R11
	wire s_edge  = slave & (st == SSP_SHIFT) & ce_ok & (sclk_s != sclk_d);
	wire lead    = (m_tick & (sclk_o == pol)) | (s_edge & (sclk_s != pol)); // R12
	wire trail   = (m_tick & (sclk_o != pol)) | (s_edge & (sclk_s == pol)); // R12
	wire samp    = pha ? trail : lead; // R9 R12
	wire pres    = pha ? lead : trail; // R9 R12
	wire [5:0] bits_n = bits + 6'(samp);
	wire fin     = trail & (bits_n == len); // R5
	wire ce_drop = slave & ce_use & cen_s & (st == SSP_SHIFT) & (bits != 6'd0); // R11

	// word loaded into the shift buffer
	wire [31:0] tx_src = tx_used ? txf.rdata : {tx_hi, tx_lo}; // R17
	wire [31:0] ld_val = (wsz == WORD_9) ? {23'h0, ninth, tx_src[7:0]} : tx_src; // R22
	// trailing-edge sampling takes its last bit on the finishing edge itself
	wire [31:0] rx_val = (pha ? {sh[30:0], sdi_s} : sh) & rx_mask; // R6

	// fifo connections
	assign txf.push  = wr_lo & tx_used; // R4 R5
	assign txf.wdata = {tx_hi, reg_wdata};
	assign txf.pop   = start & tx_used; // R5
	assign txf.flush = abort;
	assign txf.limit = (fmode == FIFO_NONE) ? CW'(1) : word_lim; // R24
	assign rxf.push  = fin & rx_used;
	assign rxf.wdata = rx_val;
	assign rxf.pop   = rd_lo & rx_used;
	assign rxf.flush = abort | ~rx_used;
	assign rxf.limit = word_lim; // R19

	// status, interrupt source, read mux
	wire txh  = tx_used & txf.full; // R5 R16 R20
	wire busy = (st == SSP_SHIFT) | (master & on & tx_ok & rx_ok); // R16 R18 R23
	wire irq_src = (fmode == FIFO_TX_ONLY) ? ~txf.full : // R16
		(fmode == FIFO_NONE) ? pend : (pend | ~rxf.empty); // R7 R20
	wire [31:0] rd_word = rx_used ? rxf.rdata : rx_word;
	wire [15:0] rd_cb = {10'h0, done, txh, busy, ctrl_b};
	wire [15:0] next_rdata = ~reg_rd ? 16'h0000 :
		(reg_addr == ADDR_CTRL_A) ? ctrl_a :
		(reg_addr == ADDR_CTRL_B) ? rd_cb :
		(reg_addr == ADDR_DATA_LO) ? rd_word[15:0] :
		(reg_addr == ADDR_DATA_HI) ? rd_word[31:16] : 16'h0000;

	// output pin level
	wire shows_bit = (st == SSP_SHIFT) | hold_lsb;
	wire next_sout = force_o ? idle : (shows_bit ? out_bit : idle); // R13 R14

	// registers and bus
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_a    <= CA_RESET;
			ctrl_b    <= CB_RESET; // R24
			tx_hi     <= 16'h0000; // R17
			tx_lo     <= 16'h0000; // R17
			reg_rdata <= 16'h0000;
		end
		else
		begin
			reg_rdata <= next_rdata;
			if (wr_ca)
				ctrl_a <= reg_wdata & CA_WMASK;
			if (wr_cb)
				ctrl_b <= reg_wdata[2:0];
			if (wr_hi)
				tx_hi <= reg_wdata; // R4
			if (wr_lo)
				tx_lo <= reg_wdata;
		end
	end

	// input synchronisers
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			sclk_m <= 1'b0;
			sclk_s <= 1'b0;
			sclk_d <= 1'b0;
			sdi_m  <= 1'b0;
			sdi_s  <= 1'b0;
			cen_m  <= 1'b1;
			cen_s  <= 1'b1;
		end
		else
		begin
			sclk_m <= sclk_i;
			sclk_s <= sclk_m;
			sclk_d <= sclk_s;
			sdi_m  <= serial_in_pin;
			sdi_s  <= sdi_m;
			cen_m  <= chip_enable_n;
			cen_s  <= cen_m;
		end
	end

	// flags set by hardware win over a clear write
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			pend     <= 1'b0;
			done     <= 1'b0;
			rx_word  <= 32'h0000_0000;
			irq_line <= 1'b0;
		end
		else
		begin
			pend     <= fin | (pend & ~wr_clr); // R6 R7
			done     <= fin | (done & ~wr_clr); // R6
			irq_line <= irq_en & irq_src; // R7
			if (fin & ~rx_used)
				rx_word <= rx_val; // R6 R15
		end
	end

	// master line clock
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			div_cnt <= 4'h0;
			sclk_o  <= 1'b0;
			sclk_oe <= 1'b0;
		end
		else
		begin
			sclk_oe <= on & master; // R8
			if (st != SSP_SHIFT || m_tick)
				div_cnt <= 4'h0;
			else
				div_cnt <= div_cnt + 4'h1;
			if (st != SSP_SHIFT || fin)
				sclk_o <= pol; // R12
			else if (m_tick)
				sclk_o <= ~sclk_o; // R2
		end
	end

	// shift engine
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			st       <= SSP_IDLE;
			sh       <= 32'h0000_0000;
			ld_q     <= 32'h0000_0000;
			ld_msb   <= 1'b0;
			out_bit  <= 1'b0;
			hold_lsb <= 1'b0;
			bits     <= 6'd0;
		end
		else if (abort)
		begin
			st       <= SSP_IDLE;
			bits     <= 6'd0;
			hold_lsb <= 1'b0; // R14
		end
		else if (start)
		begin
			st     <= SSP_SHIFT; // R4 R17
			sh     <= ld_val;
			ld_q   <= ld_val;
			ld_msb <= ld_val[top];
			bits   <= 6'd0;
			if (!pha)
			begin
				out_bit  <= ld_val[top]; // R23
				hold_lsb <= 1'b0;
			end
		end
		else if (ce_drop)
		begin
			sh   <= ld_q; // R11
			bits <= 6'd0;
			if (!pha)
				out_bit <= ld_msb;
		end
		else if (st == SSP_SHIFT)
		begin
			if (samp)
				sh <= {sh[30:0], sdi_s}; // R9 R23
			if (pres && !fin)
			begin
				out_bit <= sh[top]; // R9
				hold_lsb <= 1'b0;
			end
			bits <= bits_n;
			if (fin)
			begin
				st       <= SSP_IDLE; // R6
				hold_lsb <= slave & pha; // R13 R14
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			serial_out_pin <= 1'b0;
		else
			serial_out_pin <= next_sout; // R13 R14
	end
endmodule // ssp_port
`default_nettype wire

// ==== dv/ssp_chk.sv ====
// assertions on the serial peripheral port pins
`timescale 1ns/1ps
`default_nettype none
module ssp_chk
	import ssp_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              rst,
	input wire logic [REG_AW-1:0] reg_addr,
	input wire logic [REG_DW-1:0] reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [REG_DW-1:0] reg_rdata,
	input wire logic              sclk_o,
	input wire logic              sclk_oe,
	input wire logic              serial_out_pin,
	input wire logic              irq_line
);
	logic [15:0] ctl;
	logic [1:0]  age;
	logic [3:0]  quiet;
	logic        sclk_q;
	wire         ctl_wr = reg_wr && reg_addr == ADDR_CTRL_A;
	wire         calm   = quiet == 4'hF;
	wire         master = age == 2'h3 && ctl[CA_ON] && !ctl[CA_SLAVE];

	// shadow of control_a, cycles since its write, cycles without bus or clock activity
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ctl    <= 16'h0000;
			age    <= 2'h0;
			quiet  <= 4'h0;
			sclk_q <= 1'h0;
		end
		else
		begin
			ctl    <= ctl_wr ? reg_wdata & CA_WMASK : ctl;
			age    <= ctl_wr ? 2'h0 : age + {1'h0, age != 2'h3};
			quiet  <= reg_wr || reg_rd || sclk_o != sclk_q ? 4'h0 : quiet + {3'h0, !calm};
			sclk_q <= sclk_o;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	sequence s_kick;
		reg_wr && reg_addr == ADDR_DATA_LO && master && calm;
	endsequence
	sequence s_first_edge;
		##[1:20] sclk_o != ctl[CA_POL];
	endsequence
	property p_start;
		s_kick |-> s_first_edge;
	endproperty
	property p_half_min;
		sclk_oe && $changed(sclk_o) |=> $stable(sclk_o);
	endproperty
	property p_oe;
		age == 2'h3 |-> sclk_oe == (ctl[CA_ON] && !ctl[CA_SLAVE]);
	endproperty
	property p_clk_idle;
		master && calm |-> sclk_o == ctl[CA_POL];
	endproperty
	property p_out_idle;
		master && calm |-> serial_out_pin == ctl[CA_IDLE];
	endproperty
	property p_irq_mask;
		age == 2'h3 && !ctl[CA_IRQ_EN] |-> !irq_line;
	endproperty
	property p_irq_clr;
		reg_wr && reg_addr == ADDR_IRQ_CLR && !ctl[CA_ON] |-> ##3 !irq_line [*2];
	endproperty
	property p_ctl_read;
		reg_rd && reg_addr == ADDR_CTRL_A |=> reg_rdata == ctl;
	endproperty

	a_start:    assert property (p_start) else $error("no serial clock after data write");
	a_half_min: assert property (p_half_min) else $error("serial clock half period too short");
	a_oe:       assert property (p_oe) else $error("clock enable not master and on");
	a_clk_idle: assert property (p_clk_idle) else $error("idle clock not at polarity");
	a_out_idle: assert property (p_out_idle) else $error("idle output not at idle level");
	a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt raised");
	a_irq_clr:  assert property (p_irq_clr) else $error("interrupt kept after clear");
	a_ctl_read: assert property (p_ctl_read) else $error("control readback differs");
endmodule // ssp_chk

bind ssp_port ssp_chk i_chk (
	.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .serial_out_pin(serial_out_pin), .irq_line(irq_line)
);
`default_nettype wire

// ==== dv/ssp_peer_mdl.sv ====
// behavioural serial slave device facing the port
`timescale 1ns/1ps
`default_nettype none
module ssp_peer_mdl (
	input  wire logic        sclk,
	input  wire logic        sclk_en,
	input  wire logic        mosi,
	input  wire logic        cpol,
	input  wire logic        cpha,
	input  wire logic [5:0]  len,
	input  wire logic [31:0] tx_word,
	output var logic         miso,
	output var logic [31:0]  rx_word,
	output int               edges
);
	int k;
	initial miso = 1'h1;
	task automatic arm();
		k       = 0;
		edges   = 0;
		rx_word = 32'h0;
		miso    = tx_word[len - 6'h01] ^ cpha;
	endtask
	always @(sclk)
	begin
		if (sclk_en)
		begin
			edges = edges + 1;
			if ((sclk != cpol) ^ cpha)
			begin
				rx_word = {rx_word[30:0], mosi};
				k       = k + 1;
				if (cpha && k % len == 0)
					miso <= #60 ~miso;
			end
			else
				miso = tx_word[len - 1 - k % len];
		end
	end
endmodule // ssp_peer_mdl
`default_nettype wire

// ==== dv/test_serial_peripheral_port.sv ====
// self-checking bench for the serial peripheral port
`timescale 1ns/1ps
`default_nettype none
module test_serial_peripheral_port
	import ssp_pkg::*;
;
	logic              sys_clk;
	logic              rst;
	logic [REG_AW-1:0] reg_addr;
	logic [REG_DW-1:0] reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic [REG_DW-1:0] reg_rdata;
	logic              sclk_o;
	logic              sclk_oe;
	logic              miso;
	logic              mosi;
	logic              irq_line;
	logic              pcpol;
	logic              pcpha;
	logic [5:0]        plen;
	logic [31:0]       ptx;
	logic [31:0]       p_rx;
	int                p_edges;
	logic              s_clk;
	logic              s_cen;
	int                n_mismatch;
	int                n_compared;
	int                cyc;

	ssp_port #(.DEPTH(4)) i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk_i(s_clk), .sclk_o(sclk_o),
		.sclk_oe(sclk_oe), .serial_in_pin(miso), .serial_out_pin(mosi), .chip_enable_n(s_cen), .irq_line(irq_line));
	ssp_peer_mdl i_peer (.sclk(sclk_oe ? sclk_o : s_clk), .sclk_en(sclk_oe | ~s_cen), .mosi(mosi), .cpol(pcpol),
		.cpha(pcpha), .len(plen),
		.tx_word(ptx), .miso(miso), .rx_word(p_rx), .edges(p_edges));

	task automatic test_done();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'h1;
		@(posedge sys_clk);
		reg_wr    <= 1'h0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [REG_AW-1:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd   <= 1'h1;
		@(posedge sys_clk);
		reg_rd   <= 1'h0;
		#1;
		d = {16'h0000, reg_rdata};
		@(posedge sys_clk);
	endtask
	task automatic enable(input logic [15:0] cfg);
		wr(ADDR_CTRL_A, cfg);
		wr(ADDR_CTRL_A, cfg | 16'h0001);
	endtask
	task automatic wait_edges(input int n);
		for (int j = 0; j < 3000 && p_edges < n; j++)
			@(posedge sys_clk);
		repeat (20) @(posedge sys_clk);
	endtask
	function automatic logic [31:0] mask(input int n);
		return (n >= 32) ? 32'hFFFF_FFFF : (32'h1 << n) - 32'h1;
	endfunction

	task automatic t_reset();
		logic [31:0] d;
		rd(ADDR_CTRL_A, d);
		check(d, 32'h0000_0000);
		rd(ADDR_CTRL_B, d);
		check(d, 32'h0000_0003);
		rd(5'h14, d);
		check(d, 32'h0000_0000);
	endtask
	task automatic t_reads_only();
		logic [31:0] d;
		pcpol = 1'h0;
		pcpha = 1'h0;
		plen  = 6'h08;
		ptx   = 32'h0000_00B4;
		wr(ADDR_CTRL_B, 16'h0001);
		i_peer.arm();
		enable(16'h0040);
		wait_edges(64);
		check(p_edges, 32'h40);
		check(p_rx, 32'h0);
		rd(ADDR_CTRL_B, d);
		check(d, 32'h0000_0021);
		for (int j = 0; j < 4; j++)
		begin
			rd(ADDR_DATA_LO, d);
			check(d, 32'h0000_00B4);
		end
		wr(ADDR_CTRL_A, 16'h0000);
	endtask
	task automatic t_modes();
		logic [31:0] d;
		logic [31:0] hi;
		int          len;
		for (int i = 0; i < 4; i++)
		begin
			len   = (i == 3) ? 9 : 8 << i;
			pcpol = i[0];
			pcpha = i[1];
			plen  = len[5:0];
			ptx   = 32'h9617_E2B4;
			hi    = 32'h0;
			wr(ADDR_CTRL_B, {13'h0, i == 3, 2'h3});
			enable({3'h0, i != 2, 1'h0, i[1:0], 2'h0, 1'h1, i[1:0], i[1], i[0], 2'h0});
			repeat (16) @(posedge sys_clk);
			i_peer.arm();
			if (len == 32)
				wr(ADDR_DATA_HI, 16'hC3A5);
			wr(ADDR_DATA_LO, 16'h5A3C);
			wait_edges(2 * len);
			check(p_rx, (len == 9) ? 32'h0000_013C : 32'hC3A5_5A3C & mask(len));
			check(p_edges, 2 * len);
			check({31'h0, irq_line}, {31'h0, i != 2});
			rd(ADDR_CTRL_B, d);
			check(d, {26'h0, 1'h1, 2'h0, i == 3, 2'h3});
			if (len == 32)
				rd(ADDR_DATA_HI, hi);
			rd(ADDR_DATA_LO, d);
			check({hi[15:0], d[15:0]}, 32'h9617_E2B4 & mask((len == 9) ? 8 : len));
			wr(ADDR_CTRL_A, 16'h1000);
			wr(ADDR_IRQ_CLR, 16'h0000);
			repeat (3) @(posedge sys_clk);
			check({31'h0, irq_line}, 32'h0);
			wr(ADDR_CTRL_A, 16'h0000);
		end
	endtask
	task automatic t_writes_only();
		logic [31:0] d;
		pcpol = 1'h0;
		pcpha = 1'h0;
		plen  = 6'h08;
		ptx   = 32'h0000_005A;
		wr(ADDR_CTRL_B, 16'h0002);
		enable(16'h1040);
		repeat (16) @(posedge sys_clk);
		i_peer.arm();
		check({31'h0, irq_line}, 32'h1);
		for (int j = 1; j < 5; j++)
			wr(ADDR_DATA_LO, 16'(j * 17));
		rd(ADDR_CTRL_B, d);
		check(d, 32'h0000_000A);
		wait_edges(64);
		check(p_rx, 32'h1122_3344);
		rd(ADDR_CTRL_B, d);
		check(d, 32'h0000_0022);
		rd(ADDR_DATA_LO, d);
		check(d, 32'h0000_005A);
		for (int j = 0; j < 6; j++)
			wr(ADDR_DATA_LO, 16'h00E7);
		rd(ADDR_CTRL_B, d);
		check(d, 32'h0000_003A);
		check({31'h0, irq_line}, 32'h0);
		wr(ADDR_CTRL_A, 16'h0000);
	endtask
	task automatic t_slave();
		logic [31:0] d;
		pcpol = 1'h0;
		pcpha = 1'h0;
		plen  = 6'h08;
		ptx   = 32'h0000_003C;
		wr(ADDR_CTRL_B, 16'h0003);
		enable(16'h0842);
		wr(ADDR_DATA_LO, 16'h00A5);
		i_peer.arm();
		s_cen <= 1'h0;
		repeat (8) @(posedge sys_clk);
		for (int j = 0; j < 16; j++)
		begin
			s_clk <= ~s_clk;
			repeat (8) @(posedge sys_clk);
		end
		s_cen <= 1'h1;
		repeat (8) @(posedge sys_clk);
		check(p_rx, 32'h0000_00A5);
		check(p_edges, 32'h10);
		check({31'h0, mosi}, 32'h1);
		check({31'h0, sclk_oe}, 32'h0);
		rd(ADDR_DATA_LO, d);
		check(d, 32'h0000_003C);
		wr(ADDR_CTRL_A, 16'h0000);
	endtask

	initial
	begin
		sys_clk = 1'h0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cyc = cyc + 1;
		if (cyc == 8000)
		begin
			n_mismatch = n_mismatch + 1;
			test_done();
		end
	end
	initial
	begin
		rst        = 1'h1;
		reg_addr   = 5'h00;
		reg_wdata  = 16'h0000;
		reg_wr     = 1'h0;
		reg_rd     = 1'h0;
		pcpol      = 1'h0;
		pcpha      = 1'h0;
		plen       = 6'h08;
		ptx        = 32'h0;
		s_clk      = 1'h0;
		s_cen      = 1'h1;
		n_mismatch = 0;
		n_compared = 0;
		cyc        = 0;
		repeat (16) @(posedge sys_clk);
		rst <= 1'h0;
		@(posedge sys_clk);
		t_reset();
		t_reads_only();
		t_modes();
		t_writes_only();
		t_slave();
		test_done();
	end
endmodule // test_serial_peripheral_port
`default_nettype wire
